// ===== logic/smsp_pkg.sv
package smsp_pkg;

  // Register indices as printed; byte address is four times the index
  localparam logic [7:0]  DATA_IDX  = 8'hf7;
  localparam logic [7:0]  CTRL_IDX  = 8'hf8;
  localparam logic [11:0] DATA_ADDR = {2'h0, DATA_IDX, 2'h0};
  localparam logic [11:0] CTRL_ADDR = {2'h0, CTRL_IDX, 2'h0};

  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h04;
  localparam logic [7:0] DATA_RST = 8'h00;

  // Control register field positions
  localparam int unsigned BIT_DONE = 7;
  localparam int unsigned BIT_WRITE_COLLISION_FLAG = 6;
  localparam int unsigned BIT_SPE  = 5;
  localparam int unsigned BIT_MSTR = 4;
  localparam int unsigned BIT_CLOCK_IDLE_LEVEL = 3;
  localparam int unsigned BIT_CLOCK_PHASE_SELECT = 2;
  localparam int unsigned BIT_BIT_RATE_SEL_HI = 1;
  localparam int unsigned BIT_BIT_RATE_SEL_LO = 0;

  // Half serial clock period in core cycles per rate code
  localparam logic [3:0] HALF_DIV2  = 4'h1;
  localparam logic [3:0] HALF_DIV4  = 4'h2;
  localparam logic [3:0] HALF_DIV8  = 4'h4;
  localparam logic [3:0] HALF_DIV16 = 4'h8;

  // Sixteen serial clock edges make one byte
  localparam logic [3:0] LAST_EDGE = 4'hf;

  // Synchroniser lanes
  localparam int unsigned SY_SCLK = 0;
  localparam int unsigned SY_MOSI = 1;
  localparam int unsigned SY_MISO = 2;
  localparam int unsigned SY_SSN  = 3;
  localparam int unsigned SY_W    = 4;
  localparam logic [3:0]  SY_RST  = 4'h8;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_MRUN   = 2'b01,
    ST_SSHIFT = 2'b10,
    ST_SWAIT  = 2'b11
  } smsp_state_t;

endpackage

// ===== logic/smsp_sync.sv
`timescale 1ns/1ps
module smsp_sync (
  input  wire logic   mclk_i,
  input  wire logic   rst_n_i,
  smsp_sync_if.sync   sy
);

  // Two stages per lane; only the second stage leaves this module
  genvar g;
  generate
    for (g = 0; g < smsp_pkg::SY_W; g = g + 1)
    begin : g_lane
      logic meta_ff;
      logic sync_ff;
      always_ff @(posedge mclk_i)
      begin
        if (!rst_n_i)
        begin
          meta_ff <= smsp_pkg::SY_RST[g];
          sync_ff <= smsp_pkg::SY_RST[g];
        end
        else
        begin
          meta_ff <= sy.raw[g];
          sync_ff <= meta_ff;
        end
      end
      assign sy.synced[g] = sync_ff;
    end
  endgenerate

endmodule

// ===== logic/smsp_sync_if.sv
`timescale 1ns/1ps
interface smsp_sync_if;
  logic [smsp_pkg::SY_W-1:0] raw;
  logic [smsp_pkg::SY_W-1:0] synced;
  modport sync (input raw, output synced);
  modport core (output raw, input synced);
endinterface

// ===== logic/smsp_top.sv
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/1ps
module smsp_top (
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  input  wire logic        hsel_i,
  input  wire logic [11:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  input  wire logic        sclk_i,
  output logic             sclk_o,
  output logic             sclk_oe_o,
  input  wire logic        mosi_i,
  output logic             mosi_o,
  output logic             mosi_oe_o,
  input  wire logic        miso_i,
  output logic             miso_o,
  output logic             miso_oe_o,
  input  wire logic        ss_n_i,
  output logic             spi_pins_sel_o,
  output logic             irq_o
);

  smsp_sync_if sy ();

  smsp_pkg::smsp_state_t state_ff;
  logic        done_ff;
  logic        write_collision_flag_ff;
  logic        spe_ff;
  logic        mstr_ff;
  logic        clock_idle_level_ff;
  logic        clock_phase_select_ff;
  logic [1:0]  rate_ff;
  logic [7:0]  rxbuf_ff;
  logic [7:0]  shreg_ff;
  logic        rxbit_ff;
  logic [3:0]  edge_cnt_ff;
  logic [3:0]  div_cnt_ff;
  logic        sclk_ff;
  logic        sclk_prev_ff;
  logic        sclk_oe_ff;
  logic        mosi_oe_ff;
  logic        miso_oe_ff;
  logic        aph_wr_ff;
  logic [11:0] aph_addr_ff;
  logic [31:0] hrdata_ff;
  logic        hreadyout_ff;
  logic        hresp_ff;

  logic        sclk_s;
  logic        mosi_s;
  logic        miso_s;
  logic        ssn_s;
  logic        acc;
  logic        rd_data_acc;
  logic        wr_data;
  logic        wr_ctrl;
  logic        busy;
  logic        slave_act;
  logic        m_tick;
  logic        ev;
  logic        lead;
  logic        launch;
  logic        last;
  logic        din;
  logic        set_done;
  logic [3:0]  half_m1;
  logic [7:0]  fin_byte;
  logic [7:0]  ctrl_rd;

  // Pins cross into the core clock through two stages
  assign sy.raw[smsp_pkg::SY_SCLK] = sclk_i;
  assign sy.raw[smsp_pkg::SY_MOSI] = mosi_i;
  assign sy.raw[smsp_pkg::SY_MISO] = miso_i;
  assign sy.raw[smsp_pkg::SY_SSN]  = ss_n_i;

  smsp_sync u_sync (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .sy      (sy)
  );

  assign sclk_s = sy.synced[smsp_pkg::SY_SCLK];
  assign mosi_s = sy.synced[smsp_pkg::SY_MOSI];
  assign miso_s = sy.synced[smsp_pkg::SY_MISO];
  assign ssn_s  = sy.synced[smsp_pkg::SY_SSN];

  // Bus decode; zero wait states so hready is always high
  assign acc         = hsel_i & htrans_i[1] & hready_i;
  assign rd_data_acc = acc & !hwrite_i & (haddr_i == smsp_pkg::DATA_ADDR);
  assign wr_data     = aph_wr_ff & (aph_addr_ff == smsp_pkg::DATA_ADDR);
  assign wr_ctrl     = aph_wr_ff & (aph_addr_ff == smsp_pkg::CTRL_ADDR);

  // Control readback; in slave mode bit 0 shows the select pin
  assign ctrl_rd = {done_ff, write_collision_flag_ff, spe_ff, mstr_ff, clock_idle_level_ff, clock_phase_select_ff,
                    rate_ff[1], mstr_ff ? rate_ff[0] : ssn_s};

  // Address phase capture
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      aph_wr_ff   <= 1'b0;
      aph_addr_ff <= 12'h000;
    end
    else
    begin
      aph_wr_ff   <= acc & hwrite_i;
      aph_addr_ff <= haddr_i;
    end
  end

  // Read data registered at the address phase; unmapped reads zero
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
      hrdata_ff <= 32'h0000_0000;
    else if (acc && !hwrite_i)
    begin
      case (haddr_i)
        smsp_pkg::DATA_ADDR: hrdata_ff <= {24'h00_0000, rxbuf_ff};
        smsp_pkg::CTRL_ADDR: hrdata_ff <= {24'h00_0000, ctrl_rd};
        default:             hrdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  // Response is always ready and OKAY
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      hreadyout_ff <= 1'b1;
      hresp_ff     <= 1'b0;
    end
    else
    begin
      hreadyout_ff <= 1'b1;
      hresp_ff     <= 1'b0;
    end
  end

  // Configuration bits; a mode change ends a slave byte at once, but a master byte runs on to its last edge
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      spe_ff  <= smsp_pkg::CTRL_RST[smsp_pkg::BIT_SPE];
      mstr_ff <= smsp_pkg::CTRL_RST[smsp_pkg::BIT_MSTR];
      clock_idle_level_ff <= smsp_pkg::CTRL_RST[smsp_pkg::BIT_CLOCK_IDLE_LEVEL];
      clock_phase_select_ff <= smsp_pkg::CTRL_RST[smsp_pkg::BIT_CLOCK_PHASE_SELECT];
      rate_ff <= smsp_pkg::CTRL_RST[smsp_pkg::BIT_BIT_RATE_SEL_HI:smsp_pkg::BIT_BIT_RATE_SEL_LO];
    end
    else if (wr_ctrl)
    begin
      spe_ff  <= hwdata_i[smsp_pkg::BIT_SPE];
      mstr_ff <= hwdata_i[smsp_pkg::BIT_MSTR];
      clock_idle_level_ff <= hwdata_i[smsp_pkg::BIT_CLOCK_IDLE_LEVEL];
      clock_phase_select_ff <= hwdata_i[smsp_pkg::BIT_CLOCK_PHASE_SELECT];
      rate_ff <= hwdata_i[smsp_pkg::BIT_BIT_RATE_SEL_HI:smsp_pkg::BIT_BIT_RATE_SEL_LO];
    end
  end

  // Half period length per rate code
  always_comb
  begin
    case (rate_ff)
      2'b00:   half_m1 = smsp_pkg::HALF_DIV2 - 4'h1;
      2'b01:   half_m1 = smsp_pkg::HALF_DIV4 - 4'h1;
      2'b10:   half_m1 = smsp_pkg::HALF_DIV8 - 4'h1;
      default: half_m1 = smsp_pkg::HALF_DIV16 - 4'h1;
    endcase
  end

  // One edge event per serial clock edge, from either source
  assign busy      = (state_ff != smsp_pkg::ST_IDLE);
  assign slave_act = spe_ff & !mstr_ff & !ssn_s;
  assign m_tick    = (state_ff == smsp_pkg::ST_MRUN) && (div_cnt_ff == half_m1);
  assign ev        = m_tick |
                     (slave_act & (sclk_s != sclk_prev_ff) &
                      (state_ff != smsp_pkg::ST_SWAIT) &
                      (state_ff != smsp_pkg::ST_MRUN));
  // Edge parity: even counts are leading edges from the idle level
  assign lead      = ~edge_cnt_ff[0];
  assign launch    = clock_phase_select_ff ? lead : ~lead;
  assign last      = (edge_cnt_ff == smsp_pkg::LAST_EDGE);
  assign din       = mstr_ff ? miso_s : mosi_s;
  // Phase 1 ends on a sample edge, phase 0 on a launch edge
  assign fin_byte  = clock_phase_select_ff ? {shreg_ff[6:0], din}
                             : {shreg_ff[6:0], rxbit_ff};
  assign set_done  = (ev & last & (mstr_ff | clock_phase_select_ff)) |
                     ((state_ff == smsp_pkg::ST_SWAIT) & ssn_s);

  // Transfer sequencer
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
      state_ff <= smsp_pkg::ST_IDLE;
    else if (!spe_ff)
      state_ff <= smsp_pkg::ST_IDLE;
    else
    begin
      case (state_ff)
        smsp_pkg::ST_IDLE:
          if (wr_data && mstr_ff)
            state_ff <= smsp_pkg::ST_MRUN;
          else if (ev && !mstr_ff)
            state_ff <= smsp_pkg::ST_SSHIFT;
        smsp_pkg::ST_MRUN:
          if (ev && last)
            state_ff <= smsp_pkg::ST_IDLE;
        smsp_pkg::ST_SSHIFT:
          if (mstr_ff || ssn_s)
            state_ff <= smsp_pkg::ST_IDLE;
          else if (ev && last)
            state_ff <= clock_phase_select_ff ? smsp_pkg::ST_IDLE
                                : smsp_pkg::ST_SWAIT;
        smsp_pkg::ST_SWAIT:
          if (ssn_s || mstr_ff)
            state_ff <= smsp_pkg::ST_IDLE;
        default:
          state_ff <= smsp_pkg::ST_IDLE;
      endcase
    end
  end

  // Edge count and master divider
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      edge_cnt_ff <= 4'h0;
      div_cnt_ff  <= 4'h0;
    end
    else if (!busy || (state_ff == smsp_pkg::ST_SSHIFT && ssn_s))
    begin
      edge_cnt_ff <= (ev && !mstr_ff) ? 4'h1 : 4'h0;
      div_cnt_ff  <= 4'h0;
    end
    else
    begin
      if (ev)
        edge_cnt_ff <= edge_cnt_ff + 4'h1;
      div_cnt_ff <= m_tick ? 4'h0 : div_cnt_ff + 4'h1;
    end
  end

  // Shift register: load on write, launch and sample per edge
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      shreg_ff <= smsp_pkg::DATA_RST;
      rxbit_ff <= 1'b0;
    end
    else if (wr_data && !busy)
      shreg_ff <= hwdata_i[7:0];
    else if (ev)
    begin
      if (!launch)
        rxbit_ff <= din;
      // Only the select-ended slave byte needs the copy; elsewhere the
      // last bit must hold past the final sample edge
      if (last)
      begin
        if (!mstr_ff && !clock_phase_select_ff)
          shreg_ff <= fin_byte;
      end
      else if (launch && !(clock_phase_select_ff && edge_cnt_ff == 4'h0))
        shreg_ff <= {shreg_ff[6:0], rxbit_ff};
    end
  end

  // Received byte only moves at byte end
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
      rxbuf_ff <= smsp_pkg::DATA_RST;
    else if (state_ff == smsp_pkg::ST_SWAIT && ssn_s)
      rxbuf_ff <= shreg_ff;
    else if (ev && last && (mstr_ff || clock_phase_select_ff))
      rxbuf_ff <= fin_byte;
  end

  // Flags: hardware set wins over any clear in the same cycle
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      done_ff <= smsp_pkg::CTRL_RST[smsp_pkg::BIT_DONE];
      write_collision_flag_ff <= smsp_pkg::CTRL_RST[smsp_pkg::BIT_WRITE_COLLISION_FLAG];
    end
    else
    begin
      if (set_done)
        done_ff <= 1'b1;
      else if (rd_data_acc)
        done_ff <= 1'b0;
      else if (wr_ctrl)
        done_ff <= hwdata_i[smsp_pkg::BIT_DONE];
      if (wr_data && busy)
        write_collision_flag_ff <= 1'b1;
      else if (wr_ctrl)
        write_collision_flag_ff <= hwdata_i[smsp_pkg::BIT_WRITE_COLLISION_FLAG];
    end
  end

  // Serial clock out; idle level tracks the polarity bit
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      sclk_ff      <= 1'b0;
      sclk_prev_ff <= 1'b0;
    end
    else
    begin
      sclk_prev_ff <= sclk_s;
      if (state_ff != smsp_pkg::ST_MRUN)
        sclk_ff <= clock_idle_level_ff;
      else if (m_tick)
        sclk_ff <= ~sclk_ff;
    end
  end

  // Pin directions; nothing drives from one cycle after the pins go elsewhere
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      sclk_oe_ff <= 1'b0;
      mosi_oe_ff <= 1'b0;
      miso_oe_ff <= 1'b0;
    end
    else
    begin
      sclk_oe_ff <= spe_ff & mstr_ff;
      mosi_oe_ff <= spe_ff & mstr_ff;
      miso_oe_ff <= slave_act;
    end
  end

  assign hrdata_o       = hrdata_ff;
  assign hreadyout_o    = hreadyout_ff;
  assign hresp_o        = hresp_ff;
  assign sclk_o         = sclk_ff;
  assign sclk_oe_o      = sclk_oe_ff;
  // Data leaves straight from the shift register top bit
  assign mosi_o         = shreg_ff[7];
  assign mosi_oe_o      = mosi_oe_ff;
  assign miso_o         = shreg_ff[7];
  assign miso_oe_o      = miso_oe_ff;
  assign spi_pins_sel_o = spe_ff;
  assign irq_o          = done_ff;

  property p_done_end;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (state_ff == smsp_pkg::ST_MRUN) && ev && last |=> done_ff;
  endproperty
  a_done_end: assert property (p_done_end)
    else $error("done flag not set at byte end");

  property p_done_read_clear;
    @(posedge mclk_i) disable iff (!rst_n_i)
      rd_data_acc && !set_done |=> !done_ff;
  endproperty
  a_done_read_clear: assert property (p_done_read_clear)
    else $error("data read did not clear done flag");

  property p_write_collision_flag;
    @(posedge mclk_i) disable iff (!rst_n_i)
      wr_data && busy |=> write_collision_flag_ff && ($stable(shreg_ff) || $past(ev));
  endproperty
  a_write_collision_flag: assert property (p_write_collision_flag)
    else $error("collision not flagged or byte overwritten");

  property p_pins_off;
    @(posedge mclk_i) disable iff (!rst_n_i)
      !spe_ff && $past(!spe_ff) |-> !(sclk_oe_o || mosi_oe_o || miso_oe_o);
  endproperty
  a_pins_off: assert property (p_pins_off)
    else $error("pins driven while port deselected");

  property p_idle_level;
    @(posedge mclk_i) disable iff (!rst_n_i)
      $past(state_ff != smsp_pkg::ST_MRUN) && $stable(clock_idle_level_ff)
      |-> sclk_o == clock_idle_level_ff;
  endproperty
  a_idle_level: assert property (p_idle_level)
    else $error("serial clock not at idle level");

  property p_rate16;
    @(posedge mclk_i) disable iff (!rst_n_i)
      m_tick && !last && rate_ff == 2'b11 && $stable(rate_ff)
      |=> !m_tick [*7] ##1 m_tick;
  endproperty
  a_rate16: assert property (p_rate16)
    else $error("half period wrong at divide by 16");

  property p_eight_periods;
    @(posedge mclk_i) disable iff (!rst_n_i)
      wr_data && !busy && mstr_ff && spe_ff && rate_ff == 2'b00 && !wr_ctrl
      |=> ##15 (m_tick && last) ##1 done_ff;
  endproperty
  a_eight_periods: assert property (p_eight_periods)
    else $error("master burst not sixteen edges");

  property p_master_ignores_ss;
    @(posedge mclk_i) disable iff (!rst_n_i)
      state_ff == smsp_pkg::ST_MRUN && !(ev && last) && spe_ff
      |=> state_ff == smsp_pkg::ST_MRUN;
  endproperty
  a_master_ignores_ss: assert property (p_master_ignores_ss)
    else $error("master transfer broken off");

  property p_rx_only_at_end;
    @(posedge mclk_i) disable iff (!rst_n_i)
      !$stable(rxbuf_ff) |-> $past(set_done);
  endproperty
  a_rx_only_at_end: assert property (p_rx_only_at_end)
    else $error("received byte changed mid transfer");

  property p_slave_ss_end;
    @(posedge mclk_i) disable iff (!rst_n_i)
      state_ff == smsp_pkg::ST_SWAIT && ssn_s
      |=> done_ff && state_ff == smsp_pkg::ST_IDLE;
  endproperty
  a_slave_ss_end: assert property (p_slave_ss_end)
    else $error("phase 0 slave end not at select rising");

endmodule

// ===== verification/smsp_peer.sv
`timescale 1ns/1ps
module smsp_peer (
  input  wire logic sclk_i,
  input  wire logic mosi_i,
  input  wire logic miso_i,
  output logic      sclk_o,
  output logic      mosi_o,
  output logic      miso_o,
  output logic      ss_n_o
);
  logic [7:0] tx_q;
  logic [7:0] rx_q;
  logic       clock_phase_select_q;
  logic       armed_q;
  int         edge_q;

  // Quiet lines, deselected
  initial
  begin
    {sclk_o, mosi_o, miso_o, armed_q} = 4'h0;
    ss_n_o = 1'b1;
  end

  // Slave role: follows the device's own serial clock
  always @(sclk_i)
  begin
    if (armed_q)
    begin
      if (edge_q[0] == clock_phase_select_q)
        rx_q = {rx_q[6:0], mosi_i};
      else
      begin
        miso_o = tx_q[7];
        tx_q   = {tx_q[6:0], 1'b0};
      end
      edge_q++;
      // Released line shows the inverse, never a held value
      if (edge_q == 16)
      begin
        armed_q = 1'b0;
        miso_o  = ~miso_o;
      end
    end
  end

  // Load the reply byte; phase 0 needs its first bit up front
  task automatic arm(input logic [7:0] tx, input logic clock_phase_select);
    clock_phase_select_q = clock_phase_select;
    edge_q = 0;
    tx_q   = tx;
    if (!clock_phase_select)
    begin
      miso_o = tx_q[7];
      tx_q   = {tx_q[6:0], 1'b0};
    end
    armed_q = 1'b1;
  endtask

  // Master role: 80 ns clock, idles at the polarity outside frames
  task automatic run_bits(input logic [7:0] tx, input logic clock_idle_level,
                          input logic clock_phase_select);
    sclk_o = clock_idle_level;
    #103;
    ss_n_o = 1'b0;
    tx_q   = tx;
    if (!clock_phase_select)
    begin
      mosi_o = tx_q[7];
      tx_q   = {tx_q[6:0], 1'b0};
    end
    #40;
    for (int k = 0; k < 16; k++)
    begin
      sclk_o = ~sclk_o;
      if (k[0] == clock_phase_select)
        rx_q = {rx_q[6:0], miso_i};
      else
      begin
        mosi_o = tx_q[7];
        tx_q   = {tx_q[6:0], 1'b0};
      end
      #40;
    end
    mosi_o = ~mosi_o;
  endtask

  // Deselect after the last bit
  task automatic end_frame;
    #40;
    ss_n_o = 1'b1;
  endtask
endmodule

// ===== verification/tb_spi_master_slave_port.sv
`timescale 1ns/1ps
module tb_spi_master_slave_port;
  localparam logic [11:0] CTL = smsp_pkg::CTRL_ADDR;
  localparam logic [11:0] DAT = smsp_pkg::DATA_ADDR;
  // Slave mode after reset: bit 0 reads the idle select pin
  localparam logic [31:0] CRST = {24'h0, smsp_pkg::CTRL_RST[7:1], 1'b1};
  logic        mclk_i, rst_n_i, hsel, hwrite, hresp;
  logic [11:0] haddr;
  logic [1:0]  htrans, r;
  logic [31:0] hwdata, hrdata, rd;
  wire         hready;
  logic        sclk_d, sclk_oe, mosi_d, mosi_oe, miso_d, miso_oe;
  logic        p_sclk, p_mosi, p_miso, p_ssn, pins_sel, irq;
  logic        sclk_q, clock_idle_level, clock_phase_select;
  logic [7:0]  txb, pxb, last_rx;
  int          error_cnt, tests_run, tog_cnt, cyc, t_first, t_last;
  // Shared wires: whoever has the enable drives
  wire         sclk_w = sclk_oe ? sclk_d : p_sclk;
  wire         mosi_w = mosi_oe ? mosi_d : p_mosi;
  wire         miso_w = miso_oe ? miso_d : p_miso;

  smsp_top dut (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
    .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
    .hreadyout_o(hready), .hresp_o(hresp), .sclk_i(sclk_w),
    .sclk_o(sclk_d), .sclk_oe_o(sclk_oe), .mosi_i(mosi_w),
    .mosi_o(mosi_d), .mosi_oe_o(mosi_oe), .miso_i(miso_w),
    .miso_o(miso_d), .miso_oe_o(miso_oe), .ss_n_i(p_ssn),
    .spi_pins_sel_o(pins_sel), .irq_o(irq));

  smsp_peer peer (
    .sclk_i(sclk_w), .mosi_i(mosi_w), .miso_i(miso_w), .sclk_o(p_sclk),
    .mosi_o(p_mosi), .miso_o(p_miso), .ss_n_o(p_ssn));

  // Core clock, 100 MHz
  initial
  begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  // Serial clock toggles and their spread in core cycles
  always @(posedge mclk_i)
  begin
    cyc = cyc + 1;
    if (sclk_d !== sclk_q)
    begin
      if (tog_cnt == 0)
        t_first = cyc;
      t_last  = cyc;
      tog_cnt = tog_cnt + 1;
    end
    sclk_q = sclk_d;
  end

  function automatic logic [31:0] ctrl_val(input logic m, input logic pol,
                                           input logic pha,
                                           input logic [1:0] rt);
    return {24'h0, 2'b00, 1'b1, m, pol, pha, rt};
  endfunction

  // Fifteen half periods between first and last toggle
  function automatic logic [31:0] span_exp(input logic [1:0] rt);
    return 32'(15 * (1 << rt));
  endfunction

  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic fail(input string what);
    error_cnt++;
    $display("[ERR] %s expected set seen clear", what);
    stop_test();
  endtask

  // Bounded wait: ready is only trusted at a rising edge
  task automatic wait_rdy;
    for (int n = 0; n < 40; n++)
    begin
      @(posedge mclk_i);
      if (hready === 1'b1)
        return;
    end
    fail("hready");
  endtask

  // One single word transfer: address phase, then data phase
  task automatic bus(input logic [11:0] a, input logic w,
                     input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
    check("hresp", 32'h0, {31'h0, hresp});
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask

  task automatic rdr(input logic [11:0] a);
    bus(a, 1'b0, 32'h0);
  endtask

  // Polling reads never clear the flag, only data reads do
  task automatic wait_done;
    for (int n = 0; n < 300; n++)
    begin
      rdr(CTL);
      if (rd[smsp_pkg::BIT_DONE] === 1'b1)
        return;
    end
    fail("done flag");
  endtask

  // Idle clock level may move a cycle late, so settle first
  task automatic setup(input logic [31:0] v);
    wr(CTL, v);
    repeat (3) @(negedge mclk_i);
    tog_cnt = 0;
    @(posedge mclk_i);
  endtask

  initial
  begin
    {hsel, hwrite, haddr, htrans, hwdata} = '0;
    rst_n_i = 1'b0;
    void'($urandom(21));
    repeat (2) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    @(posedge mclk_i);
    // Reset values, then an unmapped word
    rdr(CTL);
    check("ctrl rst", CRST, rd);
    rdr(DAT);
    check("data rst", {24'h0, smsp_pkg::DATA_RST}, rd);
    wr(12'h100, 32'hff);
    rdr(12'h100);
    check("unmapped", 32'h0, rd);
    rdr(CTL);
    check("ctrl kept", CRST, rd);
    check("rst pins", 32'h0, {29'h0, pins_sel, irq, sclk_oe});
    $display("test reset done");
    // Master bytes over every rate, polarity and phase
    for (int i = 0; i < 8; i++)
    begin
      r    = 2'(i);
      clock_phase_select = i[2];
      clock_idle_level = i[0] ^ i[2];
      txb  = (i == 7) ? 8'hff : 8'($urandom);
      pxb  = (i == 7) ? 8'h00 : 8'($urandom);
      setup(ctrl_val(1'b1, clock_idle_level, clock_phase_select, r));
      peer.arm(pxb, clock_phase_select);
      peer.ss_n_o <= i[0];
      check("idle clk", {31'h0, clock_idle_level}, {31'h0, sclk_d});
      check("m oe", 32'h7, {29'h0, pins_sel, sclk_oe, mosi_oe});
      wr(DAT, {24'h0, txb});
      wait_done();
      check("toggles", 32'd16, 32'(tog_cnt));
      check("span", span_exp(r), 32'(t_last - t_first));
      check("irq set", 32'h1, {31'h0, irq});
      check("mosi", {24'h0, txb}, {24'h0, peer.rx_q});
      rdr(DAT);
      // Fast rates leave the sampled line too short for the synchroniser
      if (r[1])
        check("miso", {24'h0, pxb}, rd);
      rdr(CTL);
      check("ctrl", ctrl_val(1'b1, clock_idle_level, clock_phase_select, r), rd);
      check("irq clr", 32'h0, {31'h0, irq});
      check("idle end", {31'h0, clock_idle_level}, {31'h0, sclk_d});
      peer.ss_n_o <= 1'b1;
      $display("test master %0d done", i);
    end
    // Second data write while a byte is in flight
    setup(ctrl_val(1'b1, 1'b0, 1'b1, 2'h3));
    peer.arm(8'h5a, 1'b1);
    wr(DAT, 32'ha5);
    wr(DAT, 32'h3c);
    wait_done();
    check("write_collision_flag", 32'h1, {31'h0, rd[smsp_pkg::BIT_WRITE_COLLISION_FLAG]});
    check("kept", 32'ha5, {24'h0, peer.rx_q});
    wr(CTL, ctrl_val(1'b1, 1'b0, 1'b1, 2'h3));
    rdr(CTL);
    check("flags clr", ctrl_val(1'b1, 1'b0, 1'b1, 2'h3), rd);
    rdr(DAT);
    check("rx", 32'h5a, rd);
    last_rx = 8'h5a;
    $display("test collision done");
    // Slave bytes clocked by the outside master
    for (int c = 0; c < 2; c++)
    begin
      clock_phase_select = c[0];
      clock_idle_level = 1'($urandom);
      txb  = 8'($urandom);
      pxb  = 8'($urandom);
      setup(ctrl_val(1'b0, clock_idle_level, clock_phase_select, 2'h0));
      rdr(CTL);
      check("ss high", ctrl_val(1'b0, clock_idle_level, clock_phase_select, 2'h1), rd);
      check("s oe", 32'h4, {29'h0, pins_sel, sclk_oe, mosi_oe});
      wr(DAT, {24'h0, txb});
      peer.run_bits(pxb, clock_idle_level, clock_phase_select);
      @(posedge mclk_i);
      if (!clock_phase_select)
      begin
        repeat (10) @(posedge mclk_i);
        rdr(CTL);
        check("held", ctrl_val(1'b0, clock_idle_level, clock_phase_select, 2'h0), rd);
        rdr(DAT);
        check("partial", {24'h0, last_rx}, rd);
        peer.end_frame();
        @(posedge mclk_i);
        wait_done();
      end
      else
      begin
        wait_done();
        peer.end_frame();
        @(posedge mclk_i);
      end
      check("s tx", {24'h0, txb}, {24'h0, peer.rx_q});
      rdr(DAT);
      check("s rx", {24'h0, pxb}, rd);
      last_rx = pxb;
      $display("test slave %0d done", c);
    end
    // Pins handed back to the other interface
    setup(32'h0);
    check("off", 32'h0, {29'h0, pins_sel, sclk_oe, mosi_oe});
    $display("test release done");
    stop_test();
  end
endmodule
